// *** design/ddc_defs.svh ***
// constants for the down-converter two decimation, input and profile block
// What this block does
// RULE1: main code 000 uses two half-bands, ratio 2 real or 4 complex.
// RULE2: main code 001 uses three half-bands, ratio 4 real or 8 complex.
// RULE3: main code 010 uses four half-bands, ratio 8 real or 16 complex.
// RULE4: main code 011 uses first half-band only, ratio 1 real or 2 complex.
// RULE5: main code 100 uses half-band one plus third-band, ratio 3 or 6.
// RULE6: main code 101 uses two half-bands plus third-band, ratio 6 or 12.
// RULE7: main code 110 uses three half-bands plus third-band, ratio 12 or 24.
// RULE8: main code 111 takes the ratio from the secondary four-bit field.
// RULE9: secondary field is ignored unless the main code is 111.
// RULE10: secondary 0 uses third-band plus four half-bands, ratio 48 or 24.
// RULE11: secondary 2 uses fifth-band plus half-band one, ratio 10 or 5.
// RULE12: secondary 3 uses fifth-band plus two half-bands, ratio 20 or 10.
// RULE13: secondary 4 uses fifth-band plus three half-bands, ratio 40 or 20.
// RULE14: bit 0 picks I source, bit 2 picks Q source; 0 is A, 1 is B.
// RULE15: mode 0 takes the profile index from the register field.
// RULE16: modes 1 to 4 build the index from two pin levels, upper zero.
// RULE17: modes 5 and 6 build the index from all four pin levels.
// RULE18: modes 8 and 9 count rising edges of pin A low or A high.
// RULE19: edge counter wraps to zero once it reaches the wrap field.
// RULE20: modes 10 and 11 count rising edges of pin B low or B high.
// RULE21: complex-to-real set gives real I only; clear gives valid I and Q.
// RULE22: control pins pass two flops and an edge detector before use.
// RULE23: reserved codes and modes keep the last valid configuration.
`ifndef DDC_DEFS_SVH
`define DDC_DEFS_SVH

// register indices; byte address is four times the index
`define REG_CTRL_IDX 10'h350
`define REG_INSEL_IDX 10'h351
`define REG_OSC_IDX 10'h354
`define REG_RESET 8'h00

// field positions
`define CTRL_DEC_MSB 2
`define CTRL_DEC_LSB 0
`define CTRL_C2R_BIT 3
`define INSEL_I_BIT 0
`define INSEL_Q_BIT 2
`define INSEL_SEC_MSB 7
`define INSEL_SEC_LSB 4
`define INSEL_WMASK 8'hF5
`define OSC_MODE_MSB 7
`define OSC_MODE_LSB 4
`define OSC_FIELD_MSB 3
`define OSC_FIELD_LSB 0

// pin vector positions
`define PIN_A_LO 0
`define PIN_A_HI 1
`define PIN_B_LO 2
`define PIN_B_HI 3
`define PIN_COUNT 4

// decimation codes
`define DEC_MAIN_EXT 3'h7
`define SEC_CODE_TB 4'h0
`define SEC_CODE_FB1 4'h2
`define SEC_CODE_FB2 4'h3
`define SEC_CODE_FB3 4'h4

`endif

// *** design/ddc_pkg.sv ***
// types shared by the down-converter two selection block
package ddc_pkg;

    // profile index source modes
    typedef enum logic [3:0] {
        MODE_REG = 4'h0,
        MODE_B0A0 = 4'h1,
        MODE_B1A1 = 4'h2,
        MODE_A1A0 = 4'h3,
        MODE_B1B0 = 4'h4,
        MODE_MIXED = 4'h5,
        MODE_GROUPED = 4'h6,
        MODE_EDGE_A_LO = 4'h8,
        MODE_EDGE_A_HI = 4'h9,
        MODE_EDGE_B_LO = 4'hA,
        MODE_EDGE_B_HI = 4'hB
    } osc_mode_t;

    // decoded filter chain
    typedef struct packed {
        logic half_band_stage_one;
        logic half_band_stage_two;
        logic half_band_stage_three;
        logic half_band_stage_four;
        logic third_band_stage;
        logic fifth_band_stage;
        logic [5:0] ratio;
    } decim_cfg_t;

endpackage

// *** design/pin_sync.sv ***
// two-flop synchroniser with rising edge detect for the control pins
`timescale 1ns/1ns
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 4
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // raw pins
    input wire logic [WIDTH-1:0] pins,
    // synchronised view
    output logic [WIDTH-1:0] level,
    output logic [WIDTH-1:0] rise
);

    typedef struct packed {
        logic [WIDTH-1:0] s1;
        logic [WIDTH-1:0] s2;
        logic [WIDTH-1:0] s3;
    } sync_state_t;

    sync_state_t st;
    sync_state_t next_st;

    // s1 feeds only s2; edges come from s2 against s3
    always_comb begin
        next_st.s1 = pins;
        next_st.s2 = st.s1;
        next_st.s3 = st.s2;
    end

    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign level = st.s2;
    assign rise = st.s2 & ~st.s3; // RULE22

endmodule
`default_nettype wire

// *** design/decim_decode.sv ***
// decimation code to filter chain and ratio decoder
`timescale 1ns/1ns
`default_nettype none
`include "ddc_defs.svh"
module decim_decode (
    // register fields
    input wire logic [2:0] main_code,
    input wire logic [3:0] sec_code,
    input wire logic c2r,
    // decoded chain
    output ddc_pkg::decim_cfg_t cfg,
    output logic valid
);

    // build a chain; real output halves the complex ratio
    function automatic ddc_pkg::decim_cfg_t chain(
        input logic [2:0] hbn,
        input logic tb,
        input logic fb,
        input logic [5:0] cplx,
        input logic real_out
    );
        ddc_pkg::decim_cfg_t c;
        c.half_band_stage_one = (hbn >= 3'h1);
        c.half_band_stage_two = (hbn >= 3'h2);
        c.half_band_stage_three = (hbn >= 3'h3);
        c.half_band_stage_four = (hbn >= 3'h4);
        c.third_band_stage = tb;
        c.fifth_band_stage = fb;
        c.ratio = real_out ? (cplx >> 1) : cplx;
        return c;
    endfunction

    // main code first, secondary only under the extension code
    always_comb begin
        valid = 1'b1;
        cfg = chain(3'h2, 1'b0, 1'b0, 6'h04, c2r);
        case (main_code)
            3'h0: cfg = chain(3'h2, 1'b0, 1'b0, 6'h04, c2r); // RULE1
            3'h1: cfg = chain(3'h3, 1'b0, 1'b0, 6'h08, c2r); // RULE2
            3'h2: cfg = chain(3'h4, 1'b0, 1'b0, 6'h10, c2r); // RULE3
            3'h3: cfg = chain(3'h1, 1'b0, 1'b0, 6'h02, c2r); // RULE4
            3'h4: cfg = chain(3'h1, 1'b1, 1'b0, 6'h06, c2r); // RULE5
            3'h5: cfg = chain(3'h2, 1'b1, 1'b0, 6'h0C, c2r); // RULE6
            3'h6: cfg = chain(3'h3, 1'b1, 1'b0, 6'h18, c2r); // RULE7
            default: begin
                // RULE8 RULE9
                case (sec_code)
                    `SEC_CODE_TB: cfg = chain(3'h4, 1'b1, 1'b0, 6'h30, c2r); // RULE10
                    `SEC_CODE_FB1: cfg = chain(3'h1, 1'b0, 1'b1, 6'h0A, c2r); // RULE11
                    `SEC_CODE_FB2: cfg = chain(3'h2, 1'b0, 1'b1, 6'h14, c2r); // RULE12
                    `SEC_CODE_FB3: cfg = chain(3'h3, 1'b0, 1'b1, 6'h28, c2r); // RULE13
                    default: valid = 1'b0; // RULE23
                endcase
            end
        endcase
    end

endmodule
`default_nettype wire

// *** design/ddc_decim_input_nco_select.sv ***
// register slave, input routing and profile select for down-converter two
//
// The Wishbone slave port was chosen for this implementation.
`timescale 1ns/1ns
`default_nettype none
`include "ddc_defs.svh"
module ddc_decim_input_nco_select #(
    parameter int SAMPLE_W = 16
) (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // wishbone slave
    input wire logic [11:0] wb_adr_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    input wire logic wb_we_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    output logic wb_ack_o,
    // control pins, asynchronous
    input wire logic ctrl_pin_a_lo,
    input wire logic ctrl_pin_a_hi,
    input wire logic ctrl_pin_b_lo,
    input wire logic ctrl_pin_b_hi,
    // converter samples
    input wire logic [SAMPLE_W-1:0] chan_a_sample,
    input wire logic [SAMPLE_W-1:0] chan_b_sample,
    // routed samples
    output logic [SAMPLE_W-1:0] i_sample,
    output logic [SAMPLE_W-1:0] q_sample,
    output logic q_valid,
    output logic real_only,
    // decoded filter chain
    output logic half_band_stage_one,
    output logic half_band_stage_two,
    output logic half_band_stage_three,
    output logic half_band_stage_four,
    output logic third_band_stage,
    output logic fifth_band_stage,
    output logic [5:0] decim_ratio,
    // active oscillator profile
    output logic [3:0] oscillator_profile
);

    typedef struct packed {
        logic [7:0] ctrl;
        logic [7:0] insel;
        logic [7:0] osc;
        logic ack;
        logic [31:0] rdata;
        ddc_pkg::decim_cfg_t cfg;
        ddc_pkg::osc_mode_t mode;
        logic [3:0] count;
        logic [3:0] profile;
        logic [SAMPLE_W-1:0] i_s;
        logic [SAMPLE_W-1:0] q_s;
        logic real_out;
    } state_t;

    state_t st;
    state_t next_st;

    logic [`PIN_COUNT-1:0] pin_raw;
    logic [`PIN_COUNT-1:0] pin_lvl;
    logic [`PIN_COUNT-1:0] pin_rise;
    ddc_pkg::decim_cfg_t dec_cfg;
    logic dec_valid;
    logic [9:0] reg_idx;
    logic req;
    logic [3:0] wrap;
    logic sel_rise;

    // true for mode codes that have a defined meaning
    function automatic logic mode_defined(input logic [3:0] m);
        case (m)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6,
            4'h8, 4'h9, 4'hA, 4'hB: mode_defined = 1'b1;
            default: mode_defined = 1'b0;
        endcase
    endfunction

    // true for the edge-counting modes
    function automatic logic mode_counts(input ddc_pkg::osc_mode_t m);
        mode_counts = (m == ddc_pkg::MODE_EDGE_A_LO) ||
            (m == ddc_pkg::MODE_EDGE_A_HI) ||
            (m == ddc_pkg::MODE_EDGE_B_LO) ||
            (m == ddc_pkg::MODE_EDGE_B_HI);
    endfunction

    assign pin_raw[`PIN_A_LO] = ctrl_pin_a_lo;
    assign pin_raw[`PIN_A_HI] = ctrl_pin_a_hi;
    assign pin_raw[`PIN_B_LO] = ctrl_pin_b_lo;
    assign pin_raw[`PIN_B_HI] = ctrl_pin_b_hi;

    // pins are never read before two flops
    pin_sync #(
        .WIDTH(`PIN_COUNT)
    ) u_sync (
        .core_clk(core_clk),
        .rst(rst),
        .pins(pin_raw),
        .level(pin_lvl),
        .rise(pin_rise)
    );

    decim_decode u_dec (
        .main_code(st.ctrl[`CTRL_DEC_MSB:`CTRL_DEC_LSB]),
        .sec_code(st.insel[`INSEL_SEC_MSB:`INSEL_SEC_LSB]),
        .c2r(st.ctrl[`CTRL_C2R_BIT]),
        .cfg(dec_cfg),
        .valid(dec_valid)
    );

    // bus decode; low address bits select bytes, registers are words
    assign reg_idx = wb_adr_i[11:2];
    assign req = wb_cyc_i && wb_stb_i;
    assign wrap = st.osc[`OSC_FIELD_MSB:`OSC_FIELD_LSB];

    // edge chosen by the active counting mode
    always_comb begin
        case (st.mode)
            ddc_pkg::MODE_EDGE_A_LO: sel_rise = pin_rise[`PIN_A_LO]; // RULE18
            ddc_pkg::MODE_EDGE_A_HI: sel_rise = pin_rise[`PIN_A_HI]; // RULE18
            ddc_pkg::MODE_EDGE_B_LO: sel_rise = pin_rise[`PIN_B_LO]; // RULE20
            ddc_pkg::MODE_EDGE_B_HI: sel_rise = pin_rise[`PIN_B_HI]; // RULE20
            default: sel_rise = 1'b0;
        endcase
    end

    // next-state logic for bus, config, counter and datapath
    always_comb begin
        next_st = st;
        // ack one cycle after the request, dropped the cycle after
        next_st.ack = req && !st.ack;
        next_st.rdata = st.rdata;
        if (req && !st.ack) begin
            // unmapped words read as zero and ack normally
            case (reg_idx)
                `REG_CTRL_IDX: next_st.rdata = {24'h000000, st.ctrl};
                `REG_INSEL_IDX: next_st.rdata = {24'h000000, st.insel};
                `REG_OSC_IDX: next_st.rdata = {24'h000000, st.osc};
                default: next_st.rdata = 32'h00000000;
            endcase
        end
        // writes land on the edge where the master sees ack
        if (req && st.ack && wb_we_i && wb_sel_i[0]) begin
            case (reg_idx)
                `REG_CTRL_IDX: next_st.ctrl = wb_dat_i[7:0];
                `REG_INSEL_IDX: next_st.insel = wb_dat_i[7:0] & `INSEL_WMASK;
                `REG_OSC_IDX: next_st.osc = wb_dat_i[7:0];
                default: next_st.ctrl = st.ctrl;
            endcase
        end

        // reserved settings leave the last good chain in place
        if (dec_valid) begin
            next_st.cfg = dec_cfg;
        end
        if (mode_defined(st.osc[`OSC_MODE_MSB:`OSC_MODE_LSB])) begin
            next_st.mode = ddc_pkg::osc_mode_t'(
                st.osc[`OSC_MODE_MSB:`OSC_MODE_LSB]); // RULE23
        end

        // edge counter steps to the wrap value, then back to zero
        if (mode_counts(st.mode) && sel_rise) begin
            if (st.count >= wrap) begin
                next_st.count = 4'h0; // RULE19
            end else begin
                next_st.count = st.count + 4'h1; // RULE18
            end
        end

        // profile index source
        case (st.mode)
            ddc_pkg::MODE_REG: next_st.profile = wrap; // RULE15
            ddc_pkg::MODE_B0A0: next_st.profile = {2'b00,
                pin_lvl[`PIN_B_LO], pin_lvl[`PIN_A_LO]}; // RULE16
            ddc_pkg::MODE_B1A1: next_st.profile = {2'b00,
                pin_lvl[`PIN_B_HI], pin_lvl[`PIN_A_HI]}; // RULE16
            ddc_pkg::MODE_A1A0: next_st.profile = {2'b00,
                pin_lvl[`PIN_A_HI], pin_lvl[`PIN_A_LO]}; // RULE16
            ddc_pkg::MODE_B1B0: next_st.profile = {2'b00,
                pin_lvl[`PIN_B_HI], pin_lvl[`PIN_B_LO]}; // RULE16
            ddc_pkg::MODE_MIXED: next_st.profile = {pin_lvl[`PIN_B_HI],
                pin_lvl[`PIN_A_HI], pin_lvl[`PIN_B_LO],
                pin_lvl[`PIN_A_LO]}; // RULE17
            ddc_pkg::MODE_GROUPED: next_st.profile = {pin_lvl[`PIN_B_HI],
                pin_lvl[`PIN_B_LO], pin_lvl[`PIN_A_HI],
                pin_lvl[`PIN_A_LO]}; // RULE17
            default: next_st.profile = st.count; // RULE18 RULE20
        endcase

        // input routing, Q muted in real mode
        next_st.i_s = st.insel[`INSEL_I_BIT] ? chan_b_sample
            : chan_a_sample; // RULE14
        next_st.q_s = st.insel[`INSEL_Q_BIT] ? chan_b_sample
            : chan_a_sample; // RULE14
        next_st.real_out = st.ctrl[`CTRL_C2R_BIT]; // RULE21
        if (st.ctrl[`CTRL_C2R_BIT]) begin
            next_st.q_s = '0; // RULE21
        end
    end

    // single state register; reset clears every field
    always_ff @(posedge core_clk) begin
        if (rst) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    // outputs straight from state
    assign wb_ack_o = st.ack;
    assign wb_dat_o = st.ack ? st.rdata : 32'h00000000;
    assign i_sample = st.i_s;
    assign q_sample = st.q_s;
    assign real_only = st.real_out;
    assign q_valid = !st.real_out;
    assign half_band_stage_one = st.cfg.half_band_stage_one;
    assign half_band_stage_two = st.cfg.half_band_stage_two;
    assign half_band_stage_three = st.cfg.half_band_stage_three;
    assign half_band_stage_four = st.cfg.half_band_stage_four;
    assign third_band_stage = st.cfg.third_band_stage;
    assign fifth_band_stage = st.cfg.fifth_band_stage;
    assign decim_ratio = st.cfg.ratio;
    assign oscillator_profile = st.profile;

    default clocking cb @(posedge core_clk);
    endclocking
    default disable iff (rst);

    // bus handshake
    a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held longer than one cycle");
    a_ack_after_req: assert property (req && !wb_ack_o |=> wb_ack_o)
        else $error("request not acknowledged next cycle");

    // decimation decode
    a_main_two_hb: assert property ( // RULE1
        !rst && st.ctrl[3:0] == 4'h0 |=> decim_ratio == 6'h04
        && half_band_stage_two && !half_band_stage_three)
        else $error("code 000 complex ratio wrong");
    a_main_hb1_real: assert property ( // RULE4
        st.ctrl[2:0] == 3'h3 && st.ctrl[3] |=> decim_ratio == 6'h01
        && half_band_stage_one && !half_band_stage_two)
        else $error("code 011 real ratio wrong");
    a_main_third_band: assert property ( // RULE7
        st.ctrl[2:0] == 3'h6 && !st.ctrl[3] |=> decim_ratio == 6'h18
        && third_band_stage && !half_band_stage_four)
        else $error("code 110 chain wrong");
    a_sec_third_band: assert property ( // RULE10
        st.ctrl[2:0] == 3'h7 && st.insel[7:4] == 4'h0 && !st.ctrl[3]
        |=> decim_ratio == 6'h30 && half_band_stage_four)
        else $error("secondary 0 ratio wrong");
    a_sec_fifth_real: assert property ( // RULE13
        st.ctrl[2:0] == 3'h7 && st.insel[7:4] == 4'h4 && st.ctrl[3]
        |=> decim_ratio == 6'h14 && fifth_band_stage)
        else $error("secondary 4 real ratio wrong");
    a_reserved_hold: assert property ( // RULE23
        !dec_valid |=> $stable(decim_ratio) && $stable(fifth_band_stage))
        else $error("reserved code changed the chain");

    a_main_three_hb: assert property ( // RULE2
        st.ctrl[3:0] == 4'h1
        |=> decim_ratio == 6'h08 && half_band_stage_three)
        else $error("code 001 chain wrong");
    a_main_four_hb: assert property ( // RULE3
        st.ctrl[3:0] == 4'hA
        |=> decim_ratio == 6'h08 && half_band_stage_four)
        else $error("code 010 chain wrong");
    a_main_hb_tb: assert property ( // RULE5
        st.ctrl[3:0] == 4'hC
        |=> decim_ratio == 6'h03 && third_band_stage)
        else $error("code 100 chain wrong");
    a_main_two_tb: assert property ( // RULE6
        st.ctrl[3:0] == 4'h5
        |=> decim_ratio == 6'h0C && third_band_stage)
        else $error("code 101 chain wrong");
    a_sec_fifth_one: assert property ( // RULE11
        st.ctrl[3:0] == 4'hF && st.insel[7:4] == 4'h2
        |=> decim_ratio == 6'h05 && !half_band_stage_two)
        else $error("secondary 2 chain wrong");
    a_sec_fifth_two: assert property ( // RULE12
        st.ctrl[3:0] == 4'h7 && st.insel[7:4] == 4'h3
        |=> decim_ratio == 6'h14 && fifth_band_stage)
        else $error("secondary 3 chain wrong");
    a_sec_ignored: assert property ( // RULE9
        st.ctrl[2:0] != 3'h7
        |=> !fifth_band_stage)
        else $error("secondary field used outside 111");

    // routing and real mode
    a_i_route: assert property ( // RULE14
        !rst |=> i_sample == ($past(st.insel[0]) ? $past(chan_b_sample)
        : $past(chan_a_sample)))
        else $error("I source wrong");
    a_q_real_mute: assert property ( // RULE21
        st.ctrl[3] |=> !q_valid && real_only && q_sample == '0)
        else $error("real mode left Q active");
    a_q_route: assert property ( // RULE14
        !rst && !st.ctrl[3] |=> q_sample == ($past(st.insel[2])
        ? $past(chan_b_sample) : $past(chan_a_sample)))
        else $error("Q source wrong");
    a_complex_out: assert property ( // RULE21
        !st.ctrl[3] |=> q_valid && !real_only)
        else $error("complex mode lost Q");

    // profile index
    a_profile_reg: assert property ( // RULE15
        st.mode == ddc_pkg::MODE_REG |=> oscillator_profile
        == $past(st.osc[3:0]))
        else $error("register profile not followed");
    a_profile_pins: assert property ( // RULE16
        st.mode == ddc_pkg::MODE_B0A0 |=> oscillator_profile
        == {2'b00, $past(pin_lvl[2]), $past(pin_lvl[0])})
        else $error("pin profile wrong");
    a_count_step: assert property ( // RULE18
        mode_counts(st.mode) && sel_rise && st.count < wrap
        |=> st.count == $past(st.count) + 4'h1)
        else $error("counter did not step");
    a_count_wrap: assert property ( // RULE19
        mode_counts(st.mode) && sel_rise && st.count >= wrap
        |=> st.count == 4'h0)
        else $error("counter did not wrap");
    a_profile_a_pair: assert property ( // RULE16
        st.mode == ddc_pkg::MODE_A1A0
        |=> oscillator_profile == {2'b00, $past(pin_lvl[1:0])})
        else $error("pin pair profile wrong");
    a_profile_grouped: assert property ( // RULE17
        st.mode == ddc_pkg::MODE_GROUPED
        |=> oscillator_profile == $past(pin_lvl))
        else $error("grouped profile wrong");

    // mode hold and pin edge detect
    a_mode_hold: assert property ( // RULE23
        !mode_defined(st.osc[7:4]) |=> $stable(st.mode))
        else $error("reserved mode changed the mode");
    a_rise_detect: assert property ( // RULE22
        !rst |=> pin_rise == (pin_lvl & ~$past(pin_lvl)))
        else $error("pin edge detect wrong");

    // main scenarios
    c_bus_write: cover property (req && wb_we_i ##1 wb_ack_o);
    c_count_wrap: cover property (
        mode_counts(st.mode) && sel_rise && st.count == wrap);
    c_sec_fifth: cover property (dec_valid && st.cfg.fifth_band_stage);
    c_reserved: cover property (!dec_valid ##1 dec_valid);

endmodule
`default_nettype wire

// *** tb/ctrl_stim.sv ***
// converter sample and control pin source facing the selection block
`timescale 1ns/1ns
`default_nettype none
module ctrl_stim (
    // clock
    input wire logic core_clk,
    // pin levels requested by the bench
    input wire logic [3:0] want,
    // pins and samples toward the device
    output logic [3:0] pins,
    output logic [15:0] chan_a,
    output logic [15:0] chan_b
);
    logic [15:0] cnt = 16'h0000;
    logic [3:0] lvl = 4'h0;
    // samples step every cycle so a stale or swapped route shows up
    always_ff @(posedge core_clk) begin
        cnt <= cnt + 16'h0001;
        lvl <= want;
    end
    // b is offset from a so the two channels never match
    assign chan_a = cnt;
    assign chan_b = cnt + 16'h5A5A;
    assign pins = lvl;
endmodule
`default_nettype wire

// *** tb/tb_top.sv ***
// self-checking bench for the down-converter two selection block
`timescale 1ns/1ns
`default_nettype none
module tb_top;
    typedef struct packed {
        logic [2:0] code;
        logic [7:0] insel;
        logic [5:0] stg;
        logic [5:0] ratio;
    } row_t;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [11:0] wb_adr_i = 12'h000;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] wb_dat_o;
    logic wb_we_i = 1'b0;
    logic [3:0] wb_sel_i = 4'h0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_ack_o;
    logic [3:0] want = 4'h0;
    logic [3:0] pins;
    logic [15:0] chan_a, chan_b, i_s, q_s;
    logic q_valid, real_only;
    logic [5:0] stg, ratio;
    logic [3:0] prof, cnt;
    logic [31:0] rd;
    int errors = 0;
    int n_checks = 0;
    logic [11:0] regs [3] = '{12'hD40, 12'hD44, 12'hD50};
    logic [3:0] pat [2] = '{4'hC, 4'h5};
    // code, insel, stages hb1..hb4 tb fb, complex ratio
    row_t rows [11] = '{
        '{3'h0, 8'h20, 6'h30, 6'h04},
        '{3'h1, 8'h01, 6'h38, 6'h08},
        '{3'h2, 8'h04, 6'h3C, 6'h10},
        '{3'h3, 8'h05, 6'h20, 6'h02},
        '{3'h4, 8'h00, 6'h22, 6'h06},
        '{3'h5, 8'h41, 6'h32, 6'h0C},
        '{3'h6, 8'h04, 6'h3A, 6'h18},
        '{3'h7, 8'h00, 6'h3E, 6'h30},
        '{3'h7, 8'h21, 6'h21, 6'h0A},
        '{3'h7, 8'h34, 6'h31, 6'h14},
        '{3'h7, 8'h45, 6'h39, 6'h28}};

    ddc_decim_input_nco_select u_ddc_decim_input_nco_select (
        .core_clk(core_clk), .rst(rst),
        .wb_adr_i(wb_adr_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
        .wb_we_i(wb_we_i), .wb_sel_i(wb_sel_i), .wb_cyc_i(wb_cyc_i),
        .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
        .ctrl_pin_a_lo(pins[0]), .ctrl_pin_a_hi(pins[1]),
        .ctrl_pin_b_lo(pins[2]), .ctrl_pin_b_hi(pins[3]),
        .chan_a_sample(chan_a), .chan_b_sample(chan_b),
        .i_sample(i_s), .q_sample(q_s), .q_valid(q_valid),
        .real_only(real_only),
        .half_band_stage_one(stg[5]), .half_band_stage_two(stg[4]),
        .half_band_stage_three(stg[3]), .half_band_stage_four(stg[2]),
        .third_band_stage(stg[1]), .fifth_band_stage(stg[0]),
        .decim_ratio(ratio), .oscillator_profile(prof)
    );

    ctrl_stim u_ctrl_stim (
        .core_clk(core_clk), .want(want), .pins(pins),
        .chan_a(chan_a), .chan_b(chan_b)
    );

    // 100 MHz clock
    initial begin
        forever #5 core_clk = ~core_clk;
    end

    task automatic stop_test();
        if (errors == 0 && n_checks > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [31:0] e,
            input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            errors++;
            $display("[ERR] %s expected %h seen %h", nm, e, g);
        end
    endtask

    // classic single cycle; holds everything until ack is sampled high
    task automatic wb(input logic [11:0] a, input logic we,
            input logic [3:0] sel, input logic [7:0] d);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_adr_i <= a;
        wb_we_i <= we;
        wb_sel_i <= sel;
        wb_dat_i <= {24'h000000, d};
        @(posedge core_clk);
        while (wb_ack_o !== 1'b1) @(posedge core_clk);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        wb_we_i <= 1'b0;
    endtask

    // margin over the two-edge config path and pin synchroniser
    task automatic settle();
        repeat (6) @(posedge core_clk);
        @(negedge core_clk);
    endtask

    task automatic pulse(input int i);
        @(posedge core_clk);
        want[i] <= 1'b1;
        settle();
        @(posedge core_clk);
        want[i] <= 1'b0;
        settle();
    endtask

    // index built from pin levels {b_hi, b_lo, a_hi, a_lo}
    function automatic logic [3:0] pick(input logic [3:0] m,
            input logic [3:0] p);
        case (m)
            4'h1: pick = {2'b00, p[2], p[0]};
            4'h2: pick = {2'b00, p[3], p[1]};
            4'h3: pick = {2'b00, p[1], p[0]};
            4'h4: pick = {2'b00, p[3], p[2]};
            4'h5: pick = {p[3], p[1], p[2], p[0]};
            default: pick = p;
        endcase
    endfunction

    // main sequence
    initial begin
        repeat (20) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk("decode", {6'h30, 6'h04}, {stg, ratio});
        chk("profile", 4'h0, prof);
        foreach (regs[k]) begin
            wb(regs[k], 1'b0, 4'hF, 8'h00);
            chk("reset value", 32'h0, rd);
        end
        wb(12'hD44, 1'b1, 4'hF, 8'hFF);
        wb(12'hD44, 1'b1, 4'hE, 8'h00);
        wb(12'hD44, 1'b0, 4'hF, 8'h00);
        chk("insel", 32'hF5, rd);
        wb(12'hD48, 1'b1, 4'hF, 8'hFF);
        wb(12'hD48, 1'b0, 4'hF, 8'h00);
        chk("unmapped", 32'h0, rd);
        foreach (rows[r]) begin
            for (int c = 0; c < 2; c++) begin
                wb(12'hD40, 1'b1, 4'hF, {4'h0, c[0], rows[r].code});
                wb(12'hD44, 1'b1, 4'hF, rows[r].insel);
                settle();
                chk("decode", {rows[r].stg, c[0] ? rows[r].ratio >> 1 :
                    rows[r].ratio}, {stg, ratio});
                chk("i_sample", (rows[r].insel[0] ? chan_b : chan_a)
                    - 16'h0001, i_s);
                chk("q_sample", c[0] ? 16'h0000 : (rows[r].insel[2] ?
                    chan_b : chan_a) - 16'h0001, q_s);
                chk("real_only", c[0], real_only);
                chk("q_valid", !c[0], q_valid);
            end
        end
        // reserved secondary code must not disturb the chain
        wb(12'hD44, 1'b1, 4'hF, 8'h15);
        settle();
        chk("decode", {6'h39, 6'h14}, {stg, ratio});
        wb(12'hD50, 1'b1, 4'hF, 8'h09);
        settle();
        chk("profile", 4'h9, prof);
        foreach (pat[k]) begin
            @(posedge core_clk);
            want <= pat[k];
            for (int m = 1; m < 7; m++) begin
                wb(12'hD50, 1'b1, 4'hF, {m[3:0], 4'hF});
                settle();
                chk("profile", pick(m[3:0], pat[k]), prof);
            end
        end
        // reserved mode keeps mode 6, not the register field
        wb(12'hD50, 1'b1, 4'hF, 8'h7F);
        settle();
        chk("profile", pick(4'h6, 4'h5), prof);
        @(posedge core_clk);
        want <= 4'h0;
        cnt = 4'h0;
        for (int m = 8; m < 12; m++) begin
            wb(12'hD50, 1'b1, 4'hF, {m[3:0], 4'h3});
            settle();
            for (int k = 0; k < 5; k++) begin
                pulse(m - 8);
                cnt = (cnt >= 4'h3) ? 4'h0 : cnt + 4'h1;
                chk("count", cnt, prof);
            end
            pulse((m - 8) ^ 1);
            chk("count", cnt, prof);
        end
        // second reset in mid-run clears registers and counter
        @(posedge core_clk);
        rst <= 1'b1;
        repeat (3) @(posedge core_clk);
        rst <= 1'b0;
        settle();
        chk("profile", 4'h0, prof);
        chk("decode", {6'h30, 6'h04}, {stg, ratio});
        stop_test();
    end

    // watchdog well beyond the under one thousand cycles the run needs
    initial begin
        repeat (20000) @(posedge core_clk);
        errors++;
        stop_test();
    end
endmodule
`default_nettype wire
